//--- pirq_edge_det.sv
// Single-line edge detector with selectable polarity.
`timescale 1ns/1ps
`default_nettype none
module pirq_edge_det (
   input wire logic ref_clk, // System clock.
   input wire logic sys_rst, // Synchronous active high reset.
   input wire logic pin, // Pin level, synchronous to the clock.
   input wire logic falling_sel, // Zero picks rising, one picks falling.
   output logic event_pulse // One-cycle pulse on the selected edge.
);
   logic prev_r; // Pin level of the previous cycle.

   // Remember the last pin level for edge comparison.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= pin;
      end
   end

   // Rising edge unless the select bit asks for falling.
   assign event_pulse = falling_sel ? (prev_r & ~pin) : (~prev_r & pin);
endmodule
`default_nettype wire

//--- pirq_far.sv
// Far-side model: pin drivers and processor vector service.
`timescale 1ns/1ps
`default_nettype none
module pirq_far
   import pirq_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic [7:0] lvl, // Pin levels asked by the bench.
   input wire logic serve, // Processor may take vectors.
   input wire logic [1:0] dly, // Cycles of delay before service.
   input wire pirq_req_s req, // Requests from the block.
   output logic [7:0] pins, // Pin levels toward the block.
   output pirq_ack_s ack // Service pulses.
);
   logic [1:0] wait_r; // Service delay count.
   // Pins follow the bench one edge later, so they stay synchronous.
   always_ff @(posedge ref_clk) begin
      pins <= lvl;
   end
   // One vector at a time, line zero first, after a chosen delay.
   always_ff @(posedge ref_clk) begin
      ack <= '0;
      if (sys_rst || !serve || ack != '0 || !(req.line0 || req.line1)) begin
         wait_r <= 2'h0;
      end else if (wait_r < dly) begin
         wait_r <= wait_r + 2'h1;
      end else begin
         ack.line0 <= req.line0;
         ack.line1 <= !req.line0;
         wait_r <= 2'h0;
      end
   end
endmodule
`default_nettype wire

//--- pirq_pkg.sv
// Package with register map, field positions and carrier types for the port 0 interrupt logic.
package pirq_pkg;
   // Register byte addresses on the APB slave.
   localparam logic [7:0] PIRQ_ADDR_FLAGS = 8'h00; // Line 2..7 event flags.
   localparam logic [7:0] PIRQ_ADDR_ENABLES = 8'h04; // Line 2..7 enables.
   localparam logic [7:0] PIRQ_ADDR_EDGES = 8'h08; // Edge selects, all lines.
   localparam logic [7:0] PIRQ_ADDR_SYS_FLAG = 8'h0C; // First system flag register.
   localparam logic [7:0] PIRQ_ADDR_SYS_EN = 8'h10; // First system enable register.
   localparam logic [7:0] PIRQ_ADDR_CTRL = 8'h14; // Global enable control.
   localparam logic [7:0] PIRQ_ADDR_STATUS = 8'h18; // Current pin levels only.
   // Field positions inside the system registers.
   localparam int PIRQ_SYS_BIT_LINE0 = 2; // Line zero bit in system registers.
   localparam int PIRQ_SYS_BIT_LINE1 = 3; // Line one bit in system registers.
   localparam int PIRQ_CTRL_BIT_GIE = 0; // Global enable bit in control.
   // Reset values.
   localparam logic [7:0] PIRQ_RST_BYTE = 8'h00; // All interrupt bits clear at reset.
   localparam logic [7:0] PIRQ_SHARED_MASK = 8'hFC; // Lines served by the shared vector.
   // Interrupt request bundle toward the processor.
   typedef struct packed {
      logic line0; // Line zero request.
      logic line1; // Line one request.
      logic shared_req; // Shared vector request for lines 2..7.
   } pirq_req_s;
   // Service acknowledge bundle from the processor.
   typedef struct packed {
      logic line0; // Line zero vector taken.
      logic line1; // Line one vector taken.
   } pirq_ack_s;
endpackage

//--- pirq_port0.sv
// Port 0 pin interrupt logic with APB register access.
// What this block does
// - Line zero flag at system flag bit 2.
// - Line one flag at system flag bit 3.
// - Line zero enable at system enable bit 2.
// - Line one enable at system enable bit 3.
// - Edge selects for lines zero, one at bits 0,1.
// - Lines zero, one flags clear when serviced.
// - Servicing leaves enables and edge selects alone.
// - Lines 2..7 own flag, enable, edge bits.
// - Lines 2..7 share vector; software clears flags.
`timescale 1ns/1ps
`default_nettype none
module pirq_port0
   import pirq_pkg::*;
#(
   parameter int LINES = 8 // Port width; the map serves exactly eight.
) (
   input wire logic ref_clk, // 200 MHz system clock.
   input wire logic sys_rst, // Synchronous active high reset.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data, registered.
   output logic pready, // APB ready, registered.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [LINES-1:0] pins, // Port line levels.
   input wire pirq_ack_s ack, // Processor takes a single-source vector.
   output pirq_req_s req // Interrupt requests to the processor.
);
   // Refuse any port width other than the eight lines that the register map serves.
   if (LINES != 8) begin : g_bad_lines
      $error("pirq_port0 supports only eight lines");
   end

   logic [7:0] flags_r; // Event flags, bits 0 and 1 shown in system flag reg.
   logic [7:0] enables_r; // Enables, bits 0 and 1 shown in system enable reg.
   logic [7:0] edges_r; // Edge selects for all lines.
   logic gie_r; // Global interrupt enable.
   logic [7:0] events; // Edge events this cycle.
   logic [7:0] clr_mask; // Flags cleared this cycle.
   logic [31:0] rd_nxt; // Read data mux.
   logic access; // APB access phase.
   logic wr; // Write taking effect.
   logic mapped; // Address decodes to a register.
   logic [7:0] sysf_nxt; // System flag image.
   logic [7:0] syse_nxt; // System enable image.

   // One edge detector for each port line.
   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : g_line
         pirq_edge_det u_det (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .pin(pins[g]),
            .falling_sel(edges_r[g]),
            .event_pulse(events[g])
         );
      end
   endgenerate

   // The access phase lasts until pready; the first access cycle only launches the answer.
   assign access = psel & penable & ~pready;
   // A write lands only at the edge that sees pready high, so a stalled master changes nothing.
   assign wr = psel & penable & pready & pwrite & mapped;

   // Address decode for the mapped registers.
   always_comb begin
      case (paddr)
         PIRQ_ADDR_FLAGS, PIRQ_ADDR_ENABLES, PIRQ_ADDR_EDGES, PIRQ_ADDR_SYS_FLAG,
         PIRQ_ADDR_SYS_EN, PIRQ_ADDR_CTRL, PIRQ_ADDR_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // System register images place lines zero and one at bits 2 and 3.
   always_comb begin
      sysf_nxt = PIRQ_RST_BYTE;
      syse_nxt = PIRQ_RST_BYTE;
      sysf_nxt[PIRQ_SYS_BIT_LINE0] = flags_r[0];
      sysf_nxt[PIRQ_SYS_BIT_LINE1] = flags_r[1];
      syse_nxt[PIRQ_SYS_BIT_LINE0] = enables_r[0];
      syse_nxt[PIRQ_SYS_BIT_LINE1] = enables_r[1];
   end

   // Clear requests from software writes and from vector service.
   always_comb begin
      clr_mask = PIRQ_RST_BYTE;
      clr_mask[0] = ack.line0;
      clr_mask[1] = ack.line1;
      if (wr && paddr == PIRQ_ADDR_FLAGS) begin
         // Writing zero clears a shared flag; software owns them.
         clr_mask = clr_mask | (~pwdata[7:0] & PIRQ_SHARED_MASK);
      end else if (wr && paddr == PIRQ_ADDR_SYS_FLAG) begin
         clr_mask[0] = clr_mask[0] | ~pwdata[PIRQ_SYS_BIT_LINE0];
         clr_mask[1] = clr_mask[1] | ~pwdata[PIRQ_SYS_BIT_LINE1];
      end
   end

   // Event flags: a new edge wins over any clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_r <= PIRQ_RST_BYTE;
      end else begin
         flags_r <= (flags_r & ~clr_mask) | events;
      end
   end

   // Enables: only software writes change them, never servicing.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         enables_r <= PIRQ_RST_BYTE;
      end else if (wr && paddr == PIRQ_ADDR_ENABLES) begin
         enables_r[7:2] <= pwdata[7:2];
      end else if (wr && paddr == PIRQ_ADDR_SYS_EN) begin
         enables_r[0] <= pwdata[PIRQ_SYS_BIT_LINE0];
         enables_r[1] <= pwdata[PIRQ_SYS_BIT_LINE1];
      end
   end

   // Edge selects for all lines, untouched by servicing.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         edges_r <= PIRQ_RST_BYTE;
      end else if (wr && paddr == PIRQ_ADDR_EDGES) begin
         edges_r <= pwdata[7:0];
      end
   end

   // Global interrupt enable bit.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gie_r <= 1'b0;
      end else if (wr && paddr == PIRQ_ADDR_CTRL) begin
         gie_r <= pwdata[PIRQ_CTRL_BIT_GIE];
      end
   end

   // Interrupt requests, registered toward the processor.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         req <= '0;
      end else begin
         req.line0 <= flags_r[0] & enables_r[0] & gie_r & ~ack.line0;
         req.line1 <= flags_r[1] & enables_r[1] & gie_r & ~ack.line1;
         req.shared_req <= gie_r & |(flags_r & enables_r & PIRQ_SHARED_MASK);
      end
   end

   // Read data selection.
   always_comb begin
      rd_nxt = '0;
      case (paddr)
         PIRQ_ADDR_FLAGS: rd_nxt[7:0] = flags_r & PIRQ_SHARED_MASK; // Lines 2..7 only.
         PIRQ_ADDR_ENABLES: rd_nxt[7:0] = enables_r & PIRQ_SHARED_MASK; // Lines 2..7 only.
         PIRQ_ADDR_EDGES: rd_nxt[7:0] = edges_r; // All edge selects.
         PIRQ_ADDR_SYS_FLAG: rd_nxt[7:0] = sysf_nxt; // Lines zero and one flags.
         PIRQ_ADDR_SYS_EN: rd_nxt[7:0] = syse_nxt; // Lines zero and one enables.
         PIRQ_ADDR_CTRL: rd_nxt[PIRQ_CTRL_BIT_GIE] = gie_r; // Global enable.
         PIRQ_ADDR_STATUS: rd_nxt[7:0] = pins; // Current pin levels.
         default: rd_nxt = '0; // Unmapped reads as zero.
      endcase
   end

   // APB slave: one wait cycle, then ready with data and error.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access & ~mapped;
         prdata <= (access && !pwrite) ? rd_nxt : '0;
      end
   end

   // Checks on the interrupt logic.
   property p_ack_clears;
      @(posedge ref_clk) disable iff (sys_rst) ack.line0 && !events[0] |=> !flags_r[0];
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("line zero flag kept after service");
   property p_ack_keeps;
      @(posedge ref_clk) disable iff (sys_rst) (ack.line0 || ack.line1) && !wr |=> $stable(enables_r) && $stable(edges_r);
   endproperty
   a_ack_keeps: assert property (p_ack_keeps) else $error("service changed enable or edge");
   property p_event_sets;
      @(posedge ref_clk) disable iff (sys_rst) events[2] |=> flags_r[2];
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event did not set flag");
   property p_shared_sticky;
      @(posedge ref_clk) disable iff (sys_rst) flags_r[5] && !wr |=> flags_r[5];
   endproperty
   a_shared_sticky: assert property (p_shared_sticky) else $error("shared flag dropped");
   property p_shared_req;
      @(posedge ref_clk) disable iff (sys_rst) gie_r && (flags_r[3] && enables_r[3]) |=> req.shared_req;
   endproperty
   a_shared_req: assert property (p_shared_req) else $error("shared request missing");
   property p_no_gie;
      @(posedge ref_clk) disable iff (sys_rst) !gie_r |=> !req.shared_req && !req.line0 && !req.line1;
   endproperty
   a_no_gie: assert property (p_no_gie) else $error("request without global enable");
   // A read of the system flag register must show lines zero and one at bits 2 and 3.
   property p_sys_map;
      @(posedge ref_clk) disable iff (sys_rst)
         access && !pwrite && paddr == PIRQ_ADDR_SYS_FLAG
         |=> prdata[PIRQ_SYS_BIT_LINE0] == $past(flags_r[0])
         && prdata[PIRQ_SYS_BIT_LINE1] == $past(flags_r[1]);
   endproperty
   a_sys_map: assert property (p_sys_map) else $error("system register map wrong");
   property p_apb_ready;
      @(posedge ref_clk) disable iff (sys_rst) psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");
   c_shared: cover property (@(posedge ref_clk) req.shared_req);
   c_line0: cover property (@(posedge ref_clk) req.line0 ##1 ack.line0);
   c_line1: cover property (@(posedge ref_clk) req.line1 ##1 ack.line1);
   c_fall: cover property (@(posedge ref_clk) edges_r[4] && events[4]);
endmodule
`default_nettype wire

//--- tb_pirq_port0.sv
// Self-checking testbench for the port 0 pin interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module tb_pirq_port0;
   import pirq_pkg::*;
   logic ref_clk = 1'b0; // 200 MHz clock.
   logic sys_rst = 1'b1; // Reset, held at start.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
   logic [7:0] paddr = 8'h00; // APB address.
   logic [31:0] pwdata = 32'h0, prdata, r; // APB data and last read.
   logic pready, pslverr, x; // APB answer and last error.
   logic [7:0] lvl = 8'h00, pins, fl = 8'h00, en = 8'h00, es = 8'h00, pv = 8'h00; // Model.
   logic serve = 1'b0, global_irq_enable = 1'b0; // Service switch and global enable.
   logic [1:0] dly = 2'h0; // Service delay.
   pirq_ack_s ack; // Service pulses.
   pirq_req_s req; // Requests.
   int seed = 24, n_mismatch = 0, n_tests = 0; // Seed and counters.
   // Clock toggles every half period.
   always #2.5 ref_clk = ~ref_clk;
   pirq_port0 i_pirq_port0 (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .ack(ack), .req(req));
   pirq_far i_pirq_far (.ref_clk(ref_clk), .sys_rst(sys_rst), .lvl(lvl), .serve(serve),
      .dly(dly), .req(req), .pins(pins), .ack(ack));
   // Prints the verdict and ends the run.
   task automatic results;
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Compares one value and reports a mismatch.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // One APB transfer; waits for pready under a bound.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         results();
      end
      r = prdata;
      x = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Expected events: rising with select zero, falling with select one.
   function automatic logic [7:0] ev(input logic [7:0] p, input logic [7:0] n, input logic [7:0] s);
      return (~s & ~p & n) | (s & p & ~n);
   endfunction
   // Reads every register back and checks the requests.
   task automatic chk_all;
      // Flags follow a write by one edge and requests by one more, so let them settle.
      repeat (3) @(posedge ref_clk);
      chk("req", {29'h0, fl[0] & en[0] & global_irq_enable, fl[1] & en[1] & global_irq_enable,
         |(fl & en & PIRQ_SHARED_MASK) & global_irq_enable}, {29'h0, req});
      apb(1'b0, PIRQ_ADDR_FLAGS, 32'h0);
      chk("flags", {24'h0, fl & PIRQ_SHARED_MASK}, r);
      apb(1'b0, PIRQ_ADDR_SYS_FLAG, 32'h0);
      chk("sys flags", {28'h0, fl[1:0], 2'h0}, r);
      apb(1'b0, PIRQ_ADDR_ENABLES, 32'h0);
      chk("enables", {24'h0, en & PIRQ_SHARED_MASK}, r);
      apb(1'b0, PIRQ_ADDR_SYS_EN, 32'h0);
      chk("sys enables", {28'h0, en[1:0], 2'h0}, r);
      apb(1'b0, PIRQ_ADDR_EDGES, 32'h0);
      chk("edges", {24'h0, es}, r);
      apb(1'b0, PIRQ_ADDR_CTRL, 32'h0);
      chk("ctrl", {31'h0, global_irq_enable}, r);
      chk("ctrl error", 32'h0, {31'h0, x});
      apb(1'b0, PIRQ_ADDR_STATUS, 32'h0);
      chk("status", {24'h0, pv}, r);
   endtask
   // Writes enables, edge selects and global enable.
   task automatic cfg(input logic [7:0] e, input logic [7:0] s, input logic g);
      en = e;
      es = s;
      global_irq_enable = g;
      apb(1'b1, PIRQ_ADDR_ENABLES, {24'h0, e});
      apb(1'b1, PIRQ_ADDR_SYS_EN, {28'h0, e[1:0], 2'h0});
      apb(1'b1, PIRQ_ADDR_EDGES, {24'h0, s});
      apb(1'b1, PIRQ_ADDR_CTRL, {31'h0, g});
   endtask
   // Moves the pins, lets the processor serve if asked, updates the model.
   task automatic step(input logic [7:0] nv, input logic sv);
      @(posedge ref_clk);
      lvl <= nv;
      serve <= sv;
      dly <= 2'($random(seed));
      repeat (16) @(posedge ref_clk);
      serve <= 1'b0;
      fl = fl | ev(pv, nv, es);
      pv = nv;
      if (sv) fl[1:0] = fl[1:0] & ~(en[1:0] & {2{global_irq_enable}});
   endtask
   // Main sequence: reset values, corner cases, random traffic, second reset.
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      chk_all();
      apb(1'b1, 8'h1C, 32'hFF);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, x});
      chk("unmapped data", 32'h0, r);
      cfg(8'hFF, 8'h00, 1'b1);
      step(8'hFF, 1'b1);
      chk_all();
      for (int i = 0; i < 50; i++) begin
         if (i % 6 == 0) cfg(8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
         step(8'($random(seed)), 1'($random(seed)));
         if (i % 3 == 0) begin
            fl = fl & 8'($random(seed));
            apb(1'b1, PIRQ_ADDR_FLAGS, {24'h0, fl});
            apb(1'b1, PIRQ_ADDR_SYS_FLAG, {28'h0, fl[1:0], 2'h0});
         end
         chk_all();
      end
      @(posedge ref_clk);
      lvl <= 8'h00;
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      {fl, en, es, pv, global_irq_enable} = '0;
      chk_all();
      results();
   end
endmodule
`default_nettype wire
